// ===== design/pcc_map.svh
// Packet cipher constants: layouts and counts.
// Assumes byte-wide DMA and a 250 MHz system clock.
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// Configuration structure byte offsets
`define PCC_CFG_KEY      8'h00
`define PCC_CFG_CTR      8'h10
`define PCC_CFG_CTR_TOP  8'h14
`define PCC_CFG_DIR      8'h18
`define PCC_CFG_IV       8'h19
`define PCC_CFG_LAST     8'h20

// Packet layout in RAM
`define PCC_PKT_HDR      8'h00
`define PCC_PKT_LEN      8'h01
`define PCC_PKT_RFU      8'h02
`define PCC_PKT_BODY     8'h03

// Lengths
`define PCC_KS_DEFAULT   8'h1B
`define PCC_KS_MAX       8'hFB
`define PCC_MIC_LEN      8'h04
`define PCC_DEC_MIN      8'h05
`define PCC_LEN_MASK5    8'h1F
`define PCC_LEN_MASK8    8'hFF

// Block formatting flags
`define PCC_FLAG_CTR     8'h01
`define PCC_FLAG_B0      8'h49
`define PCC_AAD_LEN      16'h0001

// DMA stall limit
`define PCC_DMA_WAIT_NS  1000
`define PCC_CLK_MHZ      250
`define PCC_DMA_WAIT_CYC ((`PCC_DMA_WAIT_NS * `PCC_CLK_MHZ) / 1000)

`endif

// ===== design/pcc_pkg.sv
// Types of the packet cipher engine.
// Constants live in pcc_map.svh.
package pcc_pkg;

    typedef enum logic [3:0] {
        PCC_IDLE = 4'h0,
        PCC_CFG  = 4'h1,
        PCC_KSA  = 4'h2,
        PCC_KSW  = 4'h3,
        PCC_HDR  = 4'h4,
        PCC_HDW  = 4'h5,
        PCC_MAC0 = 4'h6,
        PCC_MAC1 = 4'h7,
        PCC_BODY = 4'h8,
        PCC_MACB = 4'h9,
        PCC_MIC  = 4'hA
    } pcc_state_e;

    typedef enum logic [1:0] {
        PCC_OWN_NONE = 2'h0,
        PCC_OWN_CCM  = 2'h1,
        PCC_OWN_AAR  = 2'h2,
        PCC_OWN_ECB  = 2'h3
    } pcc_owner_e;

    typedef logic [127:0] pcc_block_t;

endpackage

// ===== design/pcc_aes_arb.sv
// Shared AES core arbiter, three users.
// Requests are levels held until done.
`timescale 1ns/1ps
module pcc_aes_arb
    import pcc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic req_ccm,
    input  wire logic req_aar,
    input  wire logic req_ecb,
    output logic      gnt_ccm,
    output logic      gnt_aar,
    output logic      gnt_ecb,
    output logic      ecb_abort
);
    pcc_owner_e own_q;
    pcc_owner_e own_d;
    logic       abort_d;

    always_comb
    begin
        own_d   = own_q;
        abort_d = 1'b0;
        case (own_q)
            PCC_OWN_NONE:
            begin
                if (req_ccm)
                    own_d = PCC_OWN_CCM;
                else if (req_aar)
                    own_d = PCC_OWN_AAR;
                else if (req_ecb)
                    own_d = PCC_OWN_ECB;
            end
            PCC_OWN_CCM:
                if (!req_ccm)
                    own_d = PCC_OWN_NONE;
            PCC_OWN_AAR:
                if (!req_aar)
                    own_d = PCC_OWN_NONE;
            default:
            begin
                // RULE20 block cipher loses
                if (req_ccm || req_aar)
                begin
                    abort_d = 1'b1;
                    own_d   = req_ccm ? PCC_OWN_CCM : PCC_OWN_AAR;
                end
                else if (!req_ecb)
                    own_d = PCC_OWN_NONE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            own_q     <= PCC_OWN_NONE;
            gnt_ccm   <= 1'b0;
            gnt_aar   <= 1'b0;
            gnt_ecb   <= 1'b0;
            ecb_abort <= 1'b0;
        end
        else
        begin
            own_q     <= own_d;
            gnt_ccm   <= (own_d == PCC_OWN_CCM);
            gnt_aar   <= (own_d == PCC_OWN_AAR);
            gnt_ecb   <= (own_d == PCC_OWN_ECB);
            ecb_abort <= abort_d;
        end
    end
endmodule

// ===== design/pcc_engine.sv
// Packet cipher engine over byte DMA.
// Assumes an external AES-128 core and shared RAM.
// How it works
// RULE1 - Each cipher_run_task needs fresh keystream
// RULE2 - Task starts keystream, then done
// RULE3 - Structure and mode set first
// RULE4 - Keystream kept in work area
// RULE5 - Default length gives 27 byte keystream
// RULE6 - Extended length from limit, capped 251; above 240 code writes block 16 over block 0 in the work area
// RULE7 - Keystream no shorter than payload
// RULE8 - Shortcut needs pointers set early
// RULE9 - Encrypt XORs, appends four byte code
// RULE10 - Encrypt task, then done
// RULE11 - Encrypt adds four to length
// RULE12 - Zero length encrypt copies unchanged
// RULE13 - Length width chosen by mode
// RULE14 - Decrypt, verify code, report pass or fail
// RULE15 - Code covers masked header and payload
// RULE16 - Decrypt task, then done
// RULE17 - Decrypt subtracts four from length field
// RULE18 - Decrypt lengths one to four fail
// RULE19 - Zero length decrypt copies and passes
// RULE20 - Shared AES, block cipher loses
// RULE21 - AES-128 counter mode with CBC-MAC
// RULE22 - DMA idle before any done event
// RULE23 - Stalled DMA raises error
// RULE24 - Mode sampled at each task trigger
// RULE25 - Pass flag held until next decrypt
// RULE26 - No keystream, no cipher_run_task output
`timescale 1ns/1ps
`include "pcc_map.svh"
module pcc_engine
    import pcc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        keystream_gen_task,
    input  wire logic        cipher_run_task,
    input  wire logic        mode_decrypt,
    input  wire logic        mode_extended,
    input  wire logic        mode_len8,
    input  wire logic        short_ks_to_cipher_run_task,
    input  wire logic [31:0] config_struct_pointer,
    input  wire logic [31:0] input_packet_pointer,
    input  wire logic [31:0] output_packet_pointer,
    input  wire logic [31:0] work_area_pointer,
    input  wire logic [7:0]  keystream_length_limit,
    input  wire logic [7:0]  header_bit_mask,
    output logic             keystream_done_event,
    output logic             cipher_done_event,
    output logic             error_event,
    output logic             integrity_pass,
    output logic             busy,
    output logic             dma_req,
    output logic             dma_we,
    output logic [31:0]      dma_addr,
    output logic [7:0]       dma_wdata,
    input  wire logic [7:0]  dma_rdata,
    input  wire logic        dma_ack,
    output logic             aes_start,
    output pcc_pkg::pcc_block_t aes_key,
    output pcc_pkg::pcc_block_t aes_block,
    input  wire pcc_pkg::pcc_block_t aes_result,
    input  wire logic        aes_done,
    input  wire logic        aar_aes_req,
    input  wire logic        ecb_aes_req,
    output logic             aar_aes_gnt,
    output logic             ecb_aes_gnt,
    output logic             block_cipher_abort_event
);
    import pcc_pkg::*;

    pcc_state_e  st_q, st_d;
    logic [1:0]  ph_q, ph_d;
    logic [7:0]  idx_q, idx_d;
    logic [4:0]  blk_n_q, blk_n_d, nb_q, nb_d;
    logic [7:0]  len_q, len_d, plen_q, plen_d, hdr_q, hdr_d, rfu_q, rfu_d;
    logic [7:0]  ks_b_q, ks_b_d, in_b_q, in_b_d;
    logic [103:0] nonce_q, nonce_d;
    pcc_block_t  key_q, key_d, mac_q, mac_d, pb_q, pb_d, res_q, res_d;
    pcc_block_t  aes_blk_d;
    logic        dec_q, dec_d, l8_q, l8_d, sc_q, sc_d;
    logic [31:0] inp_q, inp_d, outp_q, outp_d, scr_q, scr_d, cnf_q, cnf_d;
    logic        ksv_q, ksv_d, ok_q, ok_d, pass_d;
    logic        ksd_d, cd_d, err_d;
    logic        req_d, we_d, areq_q, areq_d, run_q, run_d, go_d;
    logic [31:0] addr_d;
    logic [7:0]  wd_d;
    logic [7:0]  wt_q, wt_d;
    logic        ack, fin, gnt, aes_st;
    logic [7:0]  wmask, lenf, kslen, s0b, p;
    pcc_block_t  src;
    int          k;

    function automatic logic [31:0] at(input logic [31:0] b, input logic [7:0] o, input logic [7:0] i);
        at = b + {24'h0, o} + {24'h0, i};
    endfunction

    pcc_aes_arb u_arb (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .req_ccm   (areq_q),
        .req_aar   (aar_aes_req),
        .req_ecb   (ecb_aes_req),
        .gnt_ccm   (gnt),
        .gnt_aar   (aar_aes_gnt),
        .gnt_ecb   (ecb_aes_gnt),
        .ecb_abort (block_cipher_abort_event)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        k = int'(idx_q);
        st_d = st_q; ph_d = ph_q; idx_d = idx_q; blk_n_d = blk_n_q; nb_d = nb_q;
        len_d = len_q; plen_d = plen_q; hdr_d = hdr_q; rfu_d = rfu_q;
        ks_b_d = ks_b_q; in_b_d = in_b_q; nonce_d = nonce_q; key_d = key_q;
        mac_d = mac_q; pb_d = pb_q; res_d = res_q; aes_blk_d = aes_block;
        dec_d = dec_q; l8_d = l8_q; sc_d = sc_q; inp_d = inp_q; outp_d = outp_q;
        scr_d = scr_q; cnf_d = cnf_q; ksv_d = ksv_q; ok_d = ok_q;
        pass_d = integrity_pass; ksd_d = 1'b0; cd_d = 1'b0; err_d = 1'b0;
        ack = dma_req & dma_ack;
        fin = run_q & aes_done;
        req_d = dma_req & ~dma_ack; we_d = dma_we; addr_d = dma_addr; wd_d = dma_wdata;
        areq_d = areq_q; run_d = run_q; go_d = 1'b0;
        wt_d = (dma_req && !dma_ack) ? wt_q + 8'h01 : 8'h00;
        // RULE13 length width
        wmask = l8_q ? `PCC_LEN_MASK8 : `PCC_LEN_MASK5;
        lenf  = len_q & wmask;
        // RULE5 default size, RULE6 extended size capped
        kslen = !mode_extended ? `PCC_KS_DEFAULT :
                (keystream_length_limit > `PCC_KS_MAX) ? `PCC_KS_MAX : keystream_length_limit;
        s0b = res_q[(15 - k[3:0]) * 8 +: 8];
        p   = dec_q ? (in_b_q ^ ks_b_q) : in_b_q;
        // RULE21 counter and CBC-MAC block formats
        case (st_q)
            PCC_KSA:  src = {`PCC_FLAG_CTR, nonce_q, 11'h0, blk_n_q};
            PCC_MAC0: src = {`PCC_FLAG_B0, nonce_q, 8'h00, plen_q};
            // RULE15 masked header in the code
            PCC_MAC1: src = mac_q ^ {`PCC_AAD_LEN, hdr_q & header_bit_mask, 104'h0};
            default:  src = mac_q ^ pb_q;
        endcase
        aes_st = (st_q == PCC_KSA) || (st_q == PCC_MAC0) || (st_q == PCC_MAC1) || (st_q == PCC_MACB);
        // RULE20 wait for the shared core
        if (aes_st && !areq_q)
        begin
            areq_d    = 1'b1;
            aes_blk_d = src;
        end
        else if (areq_q && gnt && !run_q)
        begin
            go_d  = 1'b1;
            run_d = 1'b1;
        end
        if (fin)
        begin
            res_d  = aes_result;
            run_d  = 1'b0;
            areq_d = 1'b0;
        end
        case (st_q)
            PCC_IDLE:
            begin
                // RULE2 start keystream, RULE24 sample mode
                if (keystream_gen_task)
                begin
                    dec_d = mode_decrypt; l8_d = mode_len8; sc_d = short_ks_to_cipher_run_task;
                    cnf_d = config_struct_pointer; scr_d = work_area_pointer;
                    inp_d = input_packet_pointer; outp_d = output_packet_pointer;
                    nb_d  = 5'(({1'b0, kslen} + 9'h00F) >> 4) + 5'h01;
                    ksv_d = 1'b0; idx_d = 8'h00; st_d = PCC_CFG;
                end
                else if (cipher_run_task)
                begin
                    dec_d = mode_decrypt; l8_d = mode_len8;
                    inp_d = input_packet_pointer; outp_d = output_packet_pointer;
                    // RULE26 refuse without keystream
                    if (!ksv_q)
                        err_d = 1'b1;
                    else
                    begin
                        // RULE1 keystream used up
                        ksv_d = 1'b0; idx_d = 8'h00; st_d = PCC_HDR;
                        // RULE25 cleared at decrypt start
                        if (mode_decrypt)
                            pass_d = 1'b0;
                    end
                end
            end
            PCC_CFG:
            begin
                if (ack)
                begin
                    if (idx_q < `PCC_CFG_CTR)
                        key_d[(15 - k) * 8 +: 8] = dma_rdata;
                    else if (idx_q < `PCC_CFG_CTR_TOP)
                        nonce_d[(28 - k) * 8 +: 8] = dma_rdata;
                    else if (idx_q == `PCC_CFG_CTR_TOP)
                        nonce_d[70:64] = dma_rdata[6:0];
                    else if (idx_q == `PCC_CFG_DIR)
                        nonce_d[71] = dma_rdata[0];
                    else if (idx_q >= `PCC_CFG_IV)
                        nonce_d[(32 - k) * 8 +: 8] = dma_rdata;
                    idx_d = idx_q + 8'h01;
                    if (idx_q == `PCC_CFG_LAST)
                    begin
                        blk_n_d = 5'h00; st_d = PCC_KSA;
                    end
                end
                else if (!dma_req)
                begin
                    req_d = 1'b1; we_d = 1'b0; addr_d = at(cnf_q, idx_q, 8'h00);
                end
            end
            PCC_KSA:
                if (fin)
                begin
                    idx_d = 8'h00; st_d = PCC_KSW;
                end
            PCC_KSW:
            begin
                // RULE4 keystream into the work area
                if (ack)
                begin
                    idx_d = idx_q + 8'h01;
                    if (idx_q[3:0] == 4'hF)
                    begin
                        blk_n_d = blk_n_q + 5'h01;
                        st_d    = PCC_KSA;
                        if (blk_n_q + 5'h01 == nb_q)
                        begin
                            // RULE2 done event, RULE22 DMA already idle
                            ksd_d = 1'b1; ksv_d = 1'b1; st_d = PCC_IDLE;
                            // Shortcut keeps sampled modes
                            if (sc_q)
                            begin
                                ksv_d = 1'b0; idx_d = 8'h00; st_d = PCC_HDR;
                                if (dec_q)
                                    pass_d = 1'b0;
                            end
                        end
                    end
                end
                else if (!dma_req)
                begin
                    req_d = 1'b1; we_d = 1'b1;
                    addr_d = at(scr_q, {blk_n_q[3:0], 4'h0}, {4'h0, idx_q[3:0]});
                    wd_d = s0b;
                end
            end
            PCC_HDR:
            begin
                if (ack)
                begin
                    idx_d = idx_q + 8'h01;
                    if (idx_q == `PCC_PKT_HDR)
                        hdr_d = dma_rdata;
                    else if (idx_q == `PCC_PKT_LEN)
                        len_d = dma_rdata;
                    else
                    begin
                        rfu_d = dma_rdata; idx_d = 8'h00; st_d = PCC_HDW;
                    end
                end
                else if (!dma_req)
                begin
                    req_d = 1'b1; we_d = 1'b0; addr_d = at(inp_q, idx_q, 8'h00);
                end
            end
            PCC_HDW:
            begin
                if (ack)
                begin
                    idx_d = idx_q + 8'h01;
                    if (idx_q == `PCC_PKT_RFU)
                    begin
                        idx_d = 8'h00; mac_d = '0; pb_d = '0;
                        plen_d = dec_q ? lenf - `PCC_MIC_LEN : lenf;
                        // RULE12 RULE19 empty packet passes through
                        if (lenf == 8'h00)
                        begin
                            cd_d = 1'b1; st_d = PCC_IDLE;
                            if (dec_q)
                                pass_d = 1'b1;
                        end
                        // RULE18 too short to carry a code
                        else if (dec_q && lenf < `PCC_DEC_MIN)
                        begin
                            cd_d = 1'b1; pass_d = 1'b0; st_d = PCC_IDLE;
                        end
                        else
                            st_d = PCC_MAC0;
                    end
                end
                else if (!dma_req)
                begin
                    req_d = 1'b1; we_d = 1'b1; addr_d = at(outp_q, idx_q, 8'h00);
                    if (idx_q == `PCC_PKT_HDR)
                        wd_d = hdr_q;
                    else if (idx_q == `PCC_PKT_RFU)
                        wd_d = rfu_q;
                    // RULE11 plus four, RULE17 minus four
                    else if (lenf == 8'h00 || (dec_q && lenf < `PCC_DEC_MIN))
                        wd_d = len_q;
                    else
                        wd_d = (len_q & ~wmask) |
                               ((dec_q ? lenf - `PCC_MIC_LEN : lenf + `PCC_MIC_LEN) & wmask);
                end
            end
            PCC_MAC0:
                if (fin)
                begin
                    mac_d = aes_result; st_d = PCC_MAC1;
                end
            PCC_MAC1:
                if (fin)
                begin
                    mac_d = aes_result; ph_d = 2'h0; st_d = PCC_BODY;
                end
            PCC_BODY:
            begin
                // RULE9 RULE14 XOR with stored keystream
                if (ack)
                begin
                    ph_d = ph_q + 2'h1;
                    if (ph_q == 2'h0)
                        ks_b_d = dma_rdata;
                    else if (ph_q == 2'h1)
                        in_b_d = dma_rdata;
                    else
                    begin
                        pb_d[(15 - k[3:0]) * 8 +: 8] = p;
                        ph_d  = 2'h0;
                        idx_d = idx_q + 8'h01;
                        if (idx_q[3:0] == 4'hF || idx_q + 8'h01 == plen_q)
                            st_d = PCC_MACB;
                    end
                end
                else if (!dma_req)
                begin
                    req_d = 1'b1; we_d = (ph_q == 2'h2); wd_d = in_b_q ^ ks_b_q;
                    if (ph_q == 2'h0)
                        addr_d = at(scr_q, 8'h10, idx_q);
                    else if (ph_q == 2'h1)
                        addr_d = at(inp_q, `PCC_PKT_BODY, idx_q);
                    else
                        addr_d = at(outp_q, `PCC_PKT_BODY, idx_q);
                end
            end
            PCC_MACB:
                if (fin)
                begin
                    mac_d = aes_result; pb_d = '0; ph_d = 2'h0;
                    st_d = PCC_BODY;
                    if (idx_q == plen_q)
                    begin
                        idx_d = 8'h00; ok_d = 1'b1; st_d = PCC_MIC;
                    end
                end
            PCC_MIC:
            begin
                // RULE9 code = MAC xor first counter block
                if (ack)
                begin
                    ph_d = ph_q + 2'h1;
                    if (ph_q == 2'h0)
                        ks_b_d = dma_rdata ^ mac_q[(15 - k) * 8 +: 8];
                    else
                    begin
                        if (dma_rdata != ks_b_q)
                            ok_d = 1'b0;
                        ph_d  = 2'h0;
                        idx_d = idx_q + 8'h01;
                        if (idx_q == `PCC_MIC_LEN - 8'h01)
                        begin
                            // RULE10 RULE16 done, RULE14 status
                            cd_d = 1'b1; st_d = PCC_IDLE;
                            if (dec_q)
                                pass_d = ok_d;
                        end
                    end
                end
                else if (!dma_req)
                begin
                    req_d = 1'b1; we_d = (ph_q == 2'h1) && !dec_q; wd_d = ks_b_q;
                    if (ph_q == 2'h0)
                        addr_d = at(scr_q, idx_q, 8'h00);
                    else
                        addr_d = at(dec_q ? inp_q : outp_q, `PCC_PKT_BODY, plen_q + idx_q);
                end
            end
            default:
                st_d = PCC_IDLE;
        endcase
        // RULE23 stalled RAM access aborts
        if (wt_q == 8'(`PCC_DMA_WAIT_CYC))
        begin
            err_d = 1'b1; req_d = 1'b0; areq_d = 1'b0; run_d = 1'b0;
            ksv_d = 1'b0; st_d = PCC_IDLE; wt_d = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_q <= PCC_IDLE; ph_q <= 2'h0; idx_q <= 8'h00; blk_n_q <= 5'h00; nb_q <= 5'h00;
            len_q <= 8'h00; plen_q <= 8'h00; hdr_q <= 8'h00; rfu_q <= 8'h00;
            ks_b_q <= 8'h00; in_b_q <= 8'h00; nonce_q <= '0; key_q <= '0;
            mac_q <= '0; pb_q <= '0; res_q <= '0; aes_block <= '0;
            dec_q <= 1'b0; l8_q <= 1'b0; sc_q <= 1'b0;
            inp_q <= '0; outp_q <= '0; scr_q <= '0; cnf_q <= '0;
            ksv_q <= 1'b0; ok_q <= 1'b0; integrity_pass <= 1'b0;
            keystream_done_event <= 1'b0; cipher_done_event <= 1'b0; error_event <= 1'b0;
            dma_req <= 1'b0; dma_we <= 1'b0; dma_addr <= '0; dma_wdata <= 8'h00;
            areq_q <= 1'b0; run_q <= 1'b0; aes_start <= 1'b0; wt_q <= 8'h00; busy <= 1'b0;
        end
        else
        begin
            st_q <= st_d; ph_q <= ph_d; idx_q <= idx_d; blk_n_q <= blk_n_d; nb_q <= nb_d;
            len_q <= len_d; plen_q <= plen_d; hdr_q <= hdr_d; rfu_q <= rfu_d;
            ks_b_q <= ks_b_d; in_b_q <= in_b_d; nonce_q <= nonce_d; key_q <= key_d;
            mac_q <= mac_d; pb_q <= pb_d; res_q <= res_d; aes_block <= aes_blk_d;
            dec_q <= dec_d; l8_q <= l8_d; sc_q <= sc_d;
            inp_q <= inp_d; outp_q <= outp_d; scr_q <= scr_d; cnf_q <= cnf_d;
            ksv_q <= ksv_d; ok_q <= ok_d; integrity_pass <= pass_d;
            keystream_done_event <= ksd_d; cipher_done_event <= cd_d; error_event <= err_d;
            dma_req <= req_d; dma_we <= we_d; dma_addr <= addr_d; dma_wdata <= wd_d;
            areq_q <= areq_d; run_q <= run_d; aes_start <= go_d; wt_q <= wt_d;
            busy <= (st_d != PCC_IDLE);
        end
    end

    assign aes_key = key_q;
endmodule

// ===== bench/pcc_ram_model.sv
// RAM and AES stand-in for the engine.
// Assumes one clock; cipher is a key XOR, bytes traceable.
`timescale 1ns/1ps
module pcc_ram_model (
    input  wire logic clk_sys, dma_req, dma_we, aes_start,
    input  wire logic [31:0] dma_addr,
    input  wire logic [7:0] dma_wdata,
    output logic [7:0] dma_rdata,
    output logic dma_ack, aes_done,
    input  wire pcc_pkg::pcc_block_t aes_key, aes_block,
    output pcc_pkg::pcc_block_t aes_result
);
    logic [7:0] mem [1024];
    logic [1:0] cnt = 2'h0;
    logic       aes_q = 1'b0;
    initial {dma_ack, aes_done, dma_rdata} = 10'h000;
    initial foreach (mem[i]) mem[i] = i < 64 ? 8'h00 : 8'hFF;
    always @(posedge clk_sys)
    begin
        cnt <= cnt + 2'h1;
        // Mixed ack delay; idle data inverts so no stale byte passes
        dma_ack <= dma_req && !dma_ack && cnt != 2'h0;
        dma_rdata <= dma_req && !dma_ack ? mem[dma_addr[9:0]] : ~dma_rdata;
        if (dma_req && dma_ack && dma_we)
            mem[dma_addr[9:0]] <= dma_wdata;
        aes_q <= aes_start;
        aes_done <= aes_q;
        if (aes_start)
            aes_result <= aes_block ^ aes_key;
    end
endmodule

// ===== bench/pcc_engine_properties.sv
// Port checks for the packet cipher engine.
// Assumes one clock domain with synchronous rst.
`timescale 1ns/1ps
module pcc_engine_props (
    input wire logic clk_sys, rst, busy, dma_req, dma_ack, error_event,
    input wire logic keystream_gen_task, cipher_run_task, integrity_pass,
    input wire logic keystream_done_event, cipher_done_event,
    input wire logic [31:0] dma_addr,
    input wire logic aar_aes_req, ecb_aes_gnt, block_cipher_abort_event
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic ks_q;
    logic ks_d;
    logic idle;
    // Keystream ready until used
    always_comb ks_d = keystream_done_event | (ks_q & !cipher_done_event & !error_event);
    always_comb idle = !busy && !keystream_gen_task && !cipher_run_task;
    always_ff @(posedge clk_sys) ks_q <= rst ? 1'b0 : ks_d;
    dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr))
        else $error("dma not held");
    dma_gap_a: assert property (dma_req && dma_ack |=> !dma_req)
        else $error("dma back to back");
    ks_quiet_a: assert property (keystream_done_event |-> !dma_req)
        else $error("dma at ks done");
    cd_quiet_a: assert property (cipher_done_event |-> !dma_req)
        else $error("dma at cipher_run_task done");
    start_busy_a: assert property (keystream_gen_task && !busy |=> busy)
        else $error("ks task lost");
    pass_hold_a: assert property (idle && !cipher_done_event |=> $stable(integrity_pass))
        else $error("pass moved idle");
    no_ks_err_a: assert property (cipher_run_task && !busy && !keystream_gen_task && !ks_q |=> error_event)
        else $error("cipher_run_task not refused");
    ecb_abort_a: assert property (ecb_aes_gnt && aar_aes_req |=> block_cipher_abort_event && !ecb_aes_gnt)
        else $error("block cipher not aborted");
    cover property (cipher_done_event && integrity_pass);
    cover property (keystream_done_event);
    cover property (block_cipher_abort_event);
endmodule
bind pcc_engine pcc_engine_props u_props (.*);

// ===== bench/ccm_packet_cipher_tb_top.sv
// Self-checking packet cipher bench.
// Assumes RAM model and bound checker.
`timescale 1ns/1ps
module ccm_packet_cipher_tb_top;
    import pcc_pkg::*;
    logic clk_sys = 0, rst = 1, keystream_gen_task = 0, cipher_run_task = 0;
    logic mode_decrypt = 0, mode_extended = 0, mode_len8 = 1, short_ks_to_cipher_run_task = 0;
    logic [31:0] config_struct_pointer = 32'h0, input_packet_pointer = 32'h200;
    logic [31:0] output_packet_pointer = 32'h300, work_area_pointer = 32'h100, dma_addr;
    logic [7:0] keystream_length_limit = 8'h28, header_bit_mask = 8'hFF, dma_rdata, dma_wdata;
    logic aar_aes_req = 0, ecb_aes_req = 0, aes_start, aes_done, dma_req, dma_we, dma_ack;
    logic keystream_done_event, cipher_done_event, error_event, integrity_pass, busy;
    logic aar_aes_gnt, ecb_aes_gnt, block_cipher_abort_event;
    logic [2:0] ev;
    logic [23:0] dl = 24'h000305, de = 24'h000301;
    pcc_block_t aes_key, aes_block, aes_result;
    int fails = 0, checks = 0, k;
    pcc_engine dut (.*);
    pcc_ram_model u_ram (.*);
    always #2 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [7:0] s, e);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic op(input logic c);
        int n;
        {cipher_run_task, keystream_gen_task} = {c, !c};
        @(posedge clk_sys) #1;
        {cipher_run_task, keystream_gen_task} = 2'h0;
        for (n = 0; n < 6000 && (keystream_done_event | cipher_done_event | error_event) !== 1'b1; n++)
            @(posedge clk_sys) #1;
        ev = {keystream_done_event, cipher_done_event, error_event};
        if (n == 6000)
            fails++;
        if (n == 6000)
            give_verdict();
        repeat (2) @(posedge clk_sys) #1;
        $display("op %0d done", c);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        #1 rst = 0;
        chk("busy", busy, 8'h00);
        op(1);
        chk("no keystream", ev, 8'h01);
        mode_len8 = 0;
        short_ks_to_cipher_run_task = 1;
        u_ram.mem[10'h201] = 8'hE1;
        u_ram.mem[10'h203] = 8'h3C;
        op(0);
        chk("ks done", ev, 8'h04);
        chk("ks tail", u_ram.mem[10'h12F], 8'h02);
        chk("ks end", u_ram.mem[10'h130], 8'hFF);
        short_ks_to_cipher_run_task = 0;
        op(1);
        chk("enc done", ev, 8'h02);
        chk("enc len", u_ram.mem[10'h301], 8'hE5);
        chk("enc byte", u_ram.mem[10'h303], 8'h3D);
        mode_extended = 1;
        mode_len8 = 1;
        op(0);
        chk("ks ext", u_ram.mem[10'h13F], 8'h03);
        u_ram.mem[10'h201] = 8'h00;
        op(1);
        chk("empty len", u_ram.mem[10'h301], 8'h00);
        chk("empty body", u_ram.mem[10'h303], 8'h3D);
        mode_decrypt = 1;
        for (k = 0; k < 3; k++)
        begin
            op(0);
            u_ram.mem[10'h201] = dl[23-8*k -: 8];
            op(1);
            chk("dec len", u_ram.mem[10'h301], de[23-8*k -: 8]);
            chk("dec pass", integrity_pass, k == 0);
        end
        ecb_aes_req = 1;
        repeat (3) @(posedge clk_sys) #1;
        aar_aes_req = 1;
        @(posedge clk_sys) #1;
        chk("abort", block_cipher_abort_event, 8'h01);
        {ecb_aes_req, aar_aes_req} = 2'h0;
        give_verdict();
    end
endmodule
